// >>> bench/gtc_far_end.sv
// far-side model: external count clock and low-power oscillator output
// assumes one system clock; both sources change just after its rising edge
`timescale 1ns/1ns
`default_nettype none
module gtc_far_end #(
  parameter int HALF = 5
) (
  input  wire logic i_clock,
  input  wire logic i_run,
  input  wire logic i_idle,
  input  wire logic i_osc_en,
  output logic      o_ext,
  output logic      o_lp
);
  logic ext_r = 1'b0;
  logic lp_r  = 1'b0;
  int   ext_n = 0;
  int   lp_n  = 0;
  // count clock toggles only inside a burst, rests at the idle level between
  always @(posedge i_clock) begin
    if (!i_run) begin
      ext_r <= i_idle;
      ext_n <= 0;
    end else if (ext_n == HALF - 1) begin
      ext_r <= !ext_r;
      ext_n <= 0;
    end else begin
      ext_n <= ext_n + 1;
    end
  end
  // oscillator runs only while the device enables it
  always @(posedge i_clock) begin
    lp_n <= (lp_n == HALF - 1) ? 0 : lp_n + 1;
    if (!i_osc_en) begin
      lp_r <= 1'b0;
    end else if (lp_n == HALF - 1) begin
      lp_r <= !lp_r;
    end
  end
  assign o_ext = i_run ? ext_r : i_idle;
  assign o_lp  = lp_r;
endmodule
`default_nettype wire

// >>> bench/gtc_timer_asserts.sv
// concurrent checks on register port, interrupt and oscillator enable
// assumes it is bound into gtc_timer and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module gtc_timer_asserts #(
  parameter int COUNT_WIDTH = 16
) (
  input wire logic       i_clock,
  input wire logic       i_sys_rst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_write,
  input wire logic       i_read,
  input wire logic [7:0] o_rdata,
  input wire logic       o_low_power_osc_enable,
  input wire logic       o_irq
);
  logic [7:0] ctrl_r;
  logic       mask_r;
  // shadows of control and mask, so reads and the irq can be predicted
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ctrl_r <= 8'h00;
      mask_r <= 1'b0;
    end else if (i_write && i_addr == gtc_pkg::ADDR_TIMER_CONTROL) begin
      ctrl_r <= i_wdata;
    end else if (i_write && i_addr == gtc_pkg::ADDR_IRQ_MASK) begin
      mask_r <= i_wdata[0];
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  osc_follow_a: assert property (
    i_write && i_addr == gtc_pkg::ADDR_TIMER_CONTROL
    |=> o_low_power_osc_enable == $past(i_wdata[gtc_pkg::BIT_LP_OSC_EN]))
    else $error("oscillator enable does not follow control write");
  osc_hold_a: assert property (
    !(i_write && i_addr == gtc_pkg::ADDR_TIMER_CONTROL) |=> $stable(o_low_power_osc_enable))
    else $error("oscillator enable moved without a control write");
  ctrl_readback_a: assert property (
    i_read && i_addr == gtc_pkg::ADDR_TIMER_CONTROL |=> o_rdata == $past(ctrl_r))
    else $error("control read differs from last write");
  rdata_idle_a: assert property (
    !i_read |=> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  irq_mask_a: assert property (
    o_irq |-> mask_r)
    else $error("interrupt high while masked");
  status_shows_a: assert property (
    i_read && i_addr == gtc_pkg::ADDR_IRQ_STATUS && o_irq |=> o_rdata[0])
    else $error("status read misses pending rollover");
  status_clear_a: assert property (
    i_read && i_addr == gtc_pkg::ADDR_IRQ_STATUS && !ctrl_r[0] && !$past(ctrl_r[0]) |=> !o_irq)
    else $error("status read did not clear the interrupt");
  stopped_quiet_a: assert property (
    !ctrl_r[0] && !$past(ctrl_r[0]) && !(i_write && i_addr == gtc_pkg::ADDR_IRQ_MASK)
    |=> !$rose(o_irq))
    else $error("interrupt rose while stopped");
  reset_clear_a: assert property (
    @(posedge i_clock) disable iff (1'b0)
    i_sys_rst |=> !o_irq && !o_low_power_osc_enable && o_rdata == 8'h00)
    else $error("outputs not cleared by reset");
endmodule
bind gtc_timer gtc_timer_asserts #(.COUNT_WIDTH(COUNT_WIDTH)) u_gtc_timer_asserts (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
  .o_low_power_osc_enable(o_low_power_osc_enable), .o_irq(o_irq));
`default_nettype wire

// >>> bench/tb_gtc_timer.sv
// self-checking bench for gtc_timer with the far-end clock model
// assumes the register map of gtc_pkg and read data one cycle after the strobe
`timescale 1ns/1ns
`default_nettype none
module tb_gtc_timer;
  localparam int HALF = 5;
  localparam int EXT_UNIT = 2 * HALF;
  logic       i_clock   = 1'b0;
  logic       i_sys_rst = 1'b1;
  logic [3:0] i_addr    = 4'h0;
  logic [7:0] i_wdata   = 8'h00;
  logic       i_write   = 1'b0;
  logic       i_read    = 1'b0;
  logic       pin       = 1'b0;
  logic       comp      = 1'b0;
  logic       ext_run   = 1'b0;
  logic       ext_idle  = 1'b0;
  logic       ext;
  logic       lp;
  logic       osc_en;
  logic       irq;
  logic [7:0] o_rdata;
  logic [7:0] rd_v;
  logic [7:0] v;
  logic [7:0] d;
  logic [15:0] w;
  logic [15:0] r;
  logic [2:0] gv;
  logic [1:0] c2;
  int         p;
  int         n_mismatch   = 0;
  int         total_checks = 0;

  gtc_timer i_gtc_timer (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
    .i_ext_count_input(ext), .i_lp_osc_out(lp), .i_gate_input_pin(pin),
    .i_second_comparator_output(comp), .o_low_power_osc_enable(osc_en), .o_irq(irq));
  gtc_far_end #(.HALF(HALF)) i_gtc_far_end (.i_clock(i_clock), .i_run(ext_run),
    .i_idle(ext_idle), .i_osc_en(osc_en), .o_ext(ext), .o_lp(lp));

  always #5 i_clock = ~i_clock;

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // strobe stands for one edge, then one idle edge, so a strobe is never set twice at once
  task automatic wr(input logic [3:0] a, input logic [7:0] dv);
    i_addr  <= a;
    i_wdata <= dv;
    i_write <= 1'b1;
    @(posedge i_clock);
    i_write <= 1'b0;
    @(posedge i_clock);
  endtask
  // read data stands in the cycle after the strobe, taken at the edge that ends it
  task automatic rd(input logic [3:0] a);
    i_addr <= a;
    i_read <= 1'b1;
    @(posedge i_clock);
    i_read <= 1'b0;
    @(posedge i_clock);
    rd_v = o_rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  // low-byte growth over exactly pc cycles; steady phase makes it exact
  task automatic rate(input int pc, output logic [7:0] dd);
    logic [7:0] a0;
    rd(gtc_pkg::ADDR_COUNT_LOW);
    a0 = rd_v;
    cyc(pc - 2);
    rd(gtc_pkg::ADDR_COUNT_LOW);
    dd = rd_v - a0;
  endtask
  function automatic logic [15:0] exp_ticks(input int pc, input int unit,
                                            input logic [1:0] code, input logic act);
    exp_ticks = act ? 16'(pc / (unit << code)) : 16'h0000;
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog, well beyond the at most 2300 or so cycles the tests need
  initial begin
    cyc(20000);
    n_mismatch++;
    results();
  end

  initial begin
    void'($urandom(32'h44d5_4755));
    cyc(8);
    i_sys_rst <= 1'b0;
    wr(4'h6, 8'hFF);
    for (int k = 0; k < 8; k++) begin
      rd(4'(k));
      chk("reset read", {8'h00, rd_v}, 16'h0000);
    end
    repeat (4) begin
      v = 8'($urandom) & 8'hFE;
      wr(gtc_pkg::ADDR_TIMER_CONTROL, v);
      rd(gtc_pkg::ADDR_TIMER_CONTROL);
      chk("control", {8'h00, rd_v}, {8'h00, v});
      chk("osc enable", {15'h0000, osc_en}, {15'h0000, v[3]});
      w = 16'($urandom);
      wr(gtc_pkg::ADDR_COUNT_LOW, w[7:0]);
      wr(gtc_pkg::ADDR_COUNT_HIGH, w[15:8]);
      rd(gtc_pkg::ADDR_COUNT_HIGH);
      r[15:8] = rd_v;
      rd(gtc_pkg::ADDR_COUNT_LOW);
      r[7:0] = rd_v;
      chk("count", r, w);
    end
    // internal clock at every prescale code, sync bit random and ignored
    for (int c = 0; c < 4; c++) begin
      wr(gtc_pkg::ADDR_TIMER_CONTROL, {2'b00, 2'(c), 1'b0, 1'($urandom), 2'b01});
      cyc(40);
      p = (gtc_pkg::INSTR_DIVIDE << c) * (4 + $urandom_range(4, 0));
      rate(p, d);
      chk("internal rate", {8'h00, d}, exp_ticks(p, gtc_pkg::INSTR_DIVIDE, 2'(c), 1'b1));
    end
    // gate: level, source and polarity; the unselected source opposes
    for (int g = 0; g < 8; g++) begin
      gv = 3'(g);
      pin  <= gv[0] ^ gv[1];
      comp <= ~(gv[0] ^ gv[1]);
      wr(gtc_pkg::ADDR_COMP_AUX, {6'h00, gv[1], 1'b0});
      wr(gtc_pkg::ADDR_TIMER_CONTROL, {gv[2], 7'h41});
      cyc(8);
      rate(32, d);
      chk("gated rate", {8'h00, d}, exp_ticks(32, 4, 2'b00, gv[0] == gv[2]));
    end
    pin  <= 1'b0;
    comp <= 1'b0;
    wr(gtc_pkg::ADDR_TIMER_CONTROL, 8'h81);
    cyc(8);
    rate(32, d);
    chk("ungated rate", {8'h00, d}, 16'h0008);
    pin <= 1'b1;
    wr(gtc_pkg::ADDR_TIMER_CONTROL, 8'hC0);
    cyc(8);
    rate(32, d);
    chk("stopped", {8'h00, d}, 16'h0000);
    // external count clock, synchronised and raw
    ext_run <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      c2 = 2'($urandom);
      wr(gtc_pkg::ADDR_TIMER_CONTROL, {2'b00, c2, 1'b0, 1'(s), 2'b11});
      cyc(60);
      p = (EXT_UNIT << c2) * 4;
      rate(p, d);
      chk("external rate", {8'h00, d}, exp_ticks(p, EXT_UNIT, c2, 1'b1));
    end
    ext_run <= 1'b0;
    wr(gtc_pkg::ADDR_TIMER_CONTROL, 8'h0B);
    cyc(60);
    rate(EXT_UNIT * 4, d);
    chk("osc rate", {8'h00, d}, 16'h0004);
    // a rise with no prior fall after enabling must not count
    wr(gtc_pkg::ADDR_TIMER_CONTROL, 8'h00);
    wr(gtc_pkg::ADDR_TIMER_CONTROL, 8'h03);
    wr(gtc_pkg::ADDR_COUNT_LOW, 8'h00);
    cyc(4);
    ext_idle <= 1'b1;
    cyc(6);
    rd(gtc_pkg::ADDR_COUNT_LOW);
    chk("first rise", {8'h00, rd_v}, 16'h0000);
    ext_idle <= 1'b0;
    cyc(6);
    ext_idle <= 1'b1;
    cyc(6);
    rd(gtc_pkg::ADDR_COUNT_LOW);
    chk("armed rise", {8'h00, rd_v}, 16'h0001);
    // count write mid-period restarts the divide-by-eight from zero
    wr(gtc_pkg::ADDR_TIMER_CONTROL, 8'h31);
    repeat (3) begin
      cyc($urandom_range(15, 0));
      wr(gtc_pkg::ADDR_COUNT_LOW, 8'h00);
      cyc(25);
      rd(gtc_pkg::ADDR_COUNT_LOW);
      chk("prescale clear", {8'h00, rd_v}, 16'h0000);
    end
    // rollover while masked, then unmask, then clear by reading status
    wr(gtc_pkg::ADDR_TIMER_CONTROL, 8'h00);
    wr(gtc_pkg::ADDR_COUNT_HIGH, 8'hFF);
    wr(gtc_pkg::ADDR_COUNT_LOW, 8'hFE);
    wr(gtc_pkg::ADDR_TIMER_CONTROL, 8'h01);
    cyc(16);
    wr(gtc_pkg::ADDR_TIMER_CONTROL, 8'h00);
    rd(gtc_pkg::ADDR_COUNT_HIGH);
    chk("wrapped high", {8'h00, rd_v}, 16'h0000);
    chk("masked irq", {15'h0000, irq}, 16'h0000);
    wr(gtc_pkg::ADDR_IRQ_MASK, 8'h01);
    chk("unmasked irq", {15'h0000, irq}, 16'h0001);
    rd(gtc_pkg::ADDR_IRQ_STATUS);
    chk("status set", {8'h00, rd_v}, 16'h0001);
    rd(gtc_pkg::ADDR_IRQ_STATUS);
    chk("status cleared", {8'h00, rd_v}, 16'h0000);
    chk("irq cleared", {15'h0000, irq}, 16'h0000);
    results();
  end
endmodule
`default_nettype wire

// >>> hdl/gtc_edge_detect.sv
// external count input edge detector with optional synchroniser
// assumes i_enable is low while the timer is stopped or internally clocked
`timescale 1ns/1ns
`default_nettype none
module gtc_edge_detect (
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  input  wire logic i_ext_level,
  input  wire logic i_skip_sync,
  input  wire logic i_enable,
  gtc_tick_if.edge_end tick
);
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic armed_r;
  logic cur_level;

  // two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= i_ext_level;
      sync2_r <= sync1_r;
    end
  end

  // skipping sync trades metastability margin for latency
  assign cur_level = i_skip_sync ? i_ext_level : sync2_r;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= cur_level;
    end
  end

  // a falling edge must be seen before the first counted rising edge
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || tick.clr || !i_enable) begin
      armed_r <= 1'b0;
    end else if (prev_r && !cur_level) begin
      armed_r <= 1'b1;
    end
  end

  assign tick.ext_edge = armed_r && !prev_r && cur_level;
endmodule
`default_nettype wire

// >>> hdl/gtc_pkg.sv
// constants shared by the gated 16-bit timer control block
// assumes a byte-wide register port and one system clock
package gtc_pkg;

  // register indices on the plain register port
  localparam logic [3:0] ADDR_TIMER_CONTROL  = 4'h0;
  localparam logic [3:0] ADDR_COUNT_LOW      = 4'h1;
  localparam logic [3:0] ADDR_COUNT_HIGH     = 4'h2;
  localparam logic [3:0] ADDR_COMP_AUX       = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STATUS     = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK       = 4'h5;

  // timer_control field positions
  localparam int BIT_RUN          = 0;
  localparam int BIT_SRC_SELECT   = 1;
  localparam int BIT_SKIP_SYNC    = 2;
  localparam int BIT_LP_OSC_EN    = 3;
  localparam int BIT_DIV_LO       = 4;
  localparam int BIT_DIV_HI       = 5;
  localparam int BIT_GATE_EN      = 6;
  localparam int BIT_GATE_INVERT  = 7;

  // comparator_aux_control and interrupt field positions
  localparam int BIT_GATE_SRC_SEL = 1;
  localparam int BIT_ROLLOVER     = 0;

  // reset values
  localparam logic [7:0]  CONTROL_RESET  = 8'h00;
  localparam logic [7:0]  COMP_AUX_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
  localparam logic [7:0]  READ_ZERO      = 8'h00;

  // instruction clock is the system clock divided by four
  localparam int          INSTR_DIVIDE   = 4;
  localparam logic [1:0]  INSTR_LAST     = 2'(INSTR_DIVIDE - 1);
  localparam logic [1:0]  INSTR_ZERO     = 2'h0;
  localparam logic [2:0]  PRESCALE_ZERO  = 3'h0;
  localparam logic [2:0]  PRESCALE_ONE   = 3'h1;

endpackage

// >>> hdl/gtc_prescaler.sv
// input prescaler dividing the gated tick by 1, 2, 4 or 8
// assumes clr is a one-cycle pulse from a count byte write
`timescale 1ns/1ns
`default_nettype none
module gtc_prescaler (
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  gtc_tick_if.pre_end tick
);
  logic [2:0] count_r;
  logic [2:0] mask;

  // mask of the count bits in use for the chosen ratio
  always_comb begin
    unique case (tick.div_sel)
      2'h0: mask = 3'h0;
      2'h1: mask = 3'h1;
      2'h2: mask = 3'h3;
      2'h3: mask = 3'h7;
    endcase
  end

  // counter is hidden from software, only reset or a count write clears it
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || tick.clr) begin
      count_r <= gtc_pkg::PRESCALE_ZERO;
    end else if (tick.in_tick) begin
      count_r <= ((count_r & mask) == mask) ? gtc_pkg::PRESCALE_ZERO
                                            : count_r + gtc_pkg::PRESCALE_ONE;
    end
  end

  assign tick.pulse = tick.in_tick && !tick.clr && ((count_r & mask) == mask);
endmodule
`default_nettype wire

// >>> hdl/gtc_tick_if.sv
// tick path between edge detector, prescaler and the timer core
// assumes all members run on the one system clock
`timescale 1ns/1ns
`default_nettype none
interface gtc_tick_if;
  logic       ext_edge;  // qualified rising edge of the external input
  logic       clr;       // prescaler and edge arm clear, on count writes
  logic       in_tick;   // gated tick into the prescaler
  logic [1:0] div_sel;   // prescale code
  logic       pulse;     // prescaler output, one increment

  modport edge_end (output ext_edge, input clr);
  modport pre_end  (input in_tick, input clr, input div_sel, output pulse);
  modport core_end (input ext_edge, output clr, output in_tick, output div_sel, input pulse);
endinterface
`default_nettype wire

// >>> hdl/gtc_timer.sv
// gated 16-bit up-counting timer: control, gate, counter, registers
// assumes a byte-wide register port with read data one cycle after the strobe
// Contract
// - with gate polarity set the timer counts while the gate is high, else while it is low.
// - when running, gate enable makes counting follow the gate; clear means always counting.
// - the prescale field divides the input clock by 8, 4, 2 or 1 for codes 11, 10, 01, 00.
// - the low-power oscillator enable turns that oscillator on as the timer clock.
// - with external source, skip-sync set passes the input raw, clear synchronises it.
// - with internal source the sync bit is ignored and the internal clock is used.
// - source select 1 counts external rising edges, 0 counts the instruction clock.
// - the run bit starts the timer when set and stops it when clear.
// - gate inversion applies to whichever gate source is selected.
// - the gate comes from the pin or the comparator, chosen in the comparator register.
// - the counter wraps from FFFFh to 0000h and sets the rollover flag.
// - a write to either count byte clears the hidden prescale counter.
// - in external mode a falling edge must precede the first counted rising edge.
// - the gate sources are the gate pin and the second comparator output.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module gtc_timer #(
  parameter int COUNT_WIDTH = 16
) (
  input  wire logic       i_clock,
  input  wire logic       i_sys_rst,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_write,
  input  wire logic       i_read,
  output logic      [7:0] o_rdata,
  input  wire logic       i_ext_count_input,
  input  wire logic       i_lp_osc_out,
  input  wire logic       i_gate_input_pin,
  input  wire logic       i_second_comparator_output,
  output logic            o_low_power_osc_enable,
  output logic            o_irq
);
  // the byte register pair fixes the count at sixteen bits
  if (COUNT_WIDTH != 16) begin : g_width_check
    $error("gtc_timer supports only a 16-bit count");
  end

  logic [7:0]  control_r;
  logic [7:0]  comp_aux_r;
  logic [15:0] count_r;
  logic        rollover_flag_r;
  logic        rollover_irq_enable_r;
  logic [1:0]  instr_div_r;
  logic [7:0]  rdata_r;

  logic        counter_run;
  logic        count_source_select;
  logic        skip_input_sync;
  logic        low_power_osc_enable;
  logic        gate_count_enable;
  logic        gate_polarity_invert;
  logic        gate_source_select;
  logic        gate_raw;
  logic        gate_active;
  logic        count_allowed;
  logic        instr_tick;
  logic        ext_level;
  logic        count_write;
  logic        rollover;
  logic        status_read;

  gtc_tick_if tick ();

  // field decode of the control registers
  assign counter_run          = control_r[gtc_pkg::BIT_RUN];
  assign count_source_select  = control_r[gtc_pkg::BIT_SRC_SELECT];
  assign skip_input_sync      = control_r[gtc_pkg::BIT_SKIP_SYNC];
  assign low_power_osc_enable = control_r[gtc_pkg::BIT_LP_OSC_EN];
  assign gate_count_enable    = control_r[gtc_pkg::BIT_GATE_EN];
  assign gate_polarity_invert = control_r[gtc_pkg::BIT_GATE_INVERT];
  assign gate_source_select   = comp_aux_r[gtc_pkg::BIT_GATE_SRC_SEL];

  // bus decode
  assign count_write = i_write && ((i_addr == gtc_pkg::ADDR_COUNT_LOW) ||
                                   (i_addr == gtc_pkg::ADDR_COUNT_HIGH));
  assign status_read = i_read && (i_addr == gtc_pkg::ADDR_IRQ_STATUS);

  // timer control register, all zero after reset
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      control_r <= gtc_pkg::CONTROL_RESET;
    end else if (i_write && (i_addr == gtc_pkg::ADDR_TIMER_CONTROL)) begin
      control_r <= i_wdata;
    end
  end

  // comparator auxiliary register, only the gate source bit acts here
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      comp_aux_r <= gtc_pkg::COMP_AUX_RESET;
    end else if (i_write && (i_addr == gtc_pkg::ADDR_COMP_AUX)) begin
      comp_aux_r <= i_wdata;
    end
  end

  // oscillator enable drives the pad cell directly
  assign o_low_power_osc_enable = low_power_osc_enable;

  // with the oscillator on, its output replaces the count pin as source
  assign ext_level = low_power_osc_enable ? i_lp_osc_out : i_ext_count_input;

  // instruction clock divider, free running so the tick phase is stable
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      instr_div_r <= gtc_pkg::INSTR_ZERO;
    end else if (instr_div_r == gtc_pkg::INSTR_LAST) begin
      instr_div_r <= gtc_pkg::INSTR_ZERO;
    end else begin
      instr_div_r <= instr_div_r + 2'h1;
    end
  end

  assign instr_tick = (instr_div_r == gtc_pkg::INSTR_LAST);

  // gate source mux and polarity; inversion sits after the mux
  assign gate_raw    = gate_source_select ? i_second_comparator_output
                                          : i_gate_input_pin;
  assign gate_active = gate_polarity_invert ? gate_raw : !gate_raw;

  // gate enable means nothing while stopped, since run gates everything
  assign count_allowed = counter_run && (!gate_count_enable || gate_active);

  // external edge detector, kept disarmed while the external path is unused
  gtc_edge_detect u_edge (
    .i_clock     (i_clock),
    .i_sys_rst   (i_sys_rst),
    .i_ext_level (ext_level),
    .i_skip_sync (skip_input_sync),
    .i_enable    (counter_run && count_source_select),
    .tick        (tick.edge_end)
  );

  // source select; the sync bit plays no part on the internal path
  assign tick.clr     = count_write;
  assign tick.div_sel = control_r[gtc_pkg::BIT_DIV_HI:gtc_pkg::BIT_DIV_LO];
  assign tick.in_tick = count_allowed &&
                        (count_source_select ? tick.ext_edge : instr_tick);

  gtc_prescaler u_prescale (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .tick      (tick.pre_end)
  );

  assign rollover = tick.pulse && (count_r == gtc_pkg::COUNT_MAX);

  // counter; a byte write takes precedence over an increment in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      count_r <= gtc_pkg::COUNT_RESET;
    end else if (i_write && (i_addr == gtc_pkg::ADDR_COUNT_LOW)) begin
      count_r[7:0] <= i_wdata;
    end else if (i_write && (i_addr == gtc_pkg::ADDR_COUNT_HIGH)) begin
      count_r[15:8] <= i_wdata;
    end else if (tick.pulse) begin
      count_r <= count_r + 16'h0001;  // wraps to zero
    end
  end

  // rollover flag is sticky; a new rollover beats a clearing read
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rollover_flag_r <= 1'b0;
    end else if (rollover) begin
      rollover_flag_r <= 1'b1;
    end else if (status_read) begin
      rollover_flag_r <= 1'b0;
    end
  end

  // interrupt mask
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rollover_irq_enable_r <= 1'b0;
    end else if (i_write && (i_addr == gtc_pkg::ADDR_IRQ_MASK)) begin
      rollover_irq_enable_r <= i_wdata[gtc_pkg::BIT_ROLLOVER];
    end
  end

  assign o_irq = rollover_flag_r && rollover_irq_enable_r;

  // read data, registered; unmapped addresses read zero
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rdata_r <= gtc_pkg::READ_ZERO;
    end else if (i_read) begin
      unique case (i_addr)
        gtc_pkg::ADDR_TIMER_CONTROL: rdata_r <= control_r;
        gtc_pkg::ADDR_COUNT_LOW:     rdata_r <= count_r[7:0];
        gtc_pkg::ADDR_COUNT_HIGH:    rdata_r <= count_r[15:8];
        gtc_pkg::ADDR_COMP_AUX:      rdata_r <= comp_aux_r;
        gtc_pkg::ADDR_IRQ_STATUS:    rdata_r <= {7'h00, rollover_flag_r};
        gtc_pkg::ADDR_IRQ_MASK:      rdata_r <= {7'h00, rollover_irq_enable_r};
        default:                     rdata_r <= gtc_pkg::READ_ZERO;
      endcase
    end else begin
      rdata_r <= gtc_pkg::READ_ZERO;  // data stands only in the cycle after the read
    end
  end

  assign o_rdata = rdata_r;
endmodule
`default_nettype wire
